// *** logic/isu_irq_status_and_midi_uart.sv ***
`timescale 1ns/1ps
module isu_irq_status_and_midi_uart (
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire isu_pkg::isu_req_t    req,
  output logic [31:0]               rdata,
  output logic                      rvalid,
  input  wire isu_pkg::isu_sources_t src,
  input  wire logic                 bus_master_irq_mask,
  input  wire logic                 power_change_irq_mask,
  input  wire logic [1:0]           current_power_level,
  input  wire logic [1:0]           config_power_state,
  input  wire logic                 uart_enable,
  input  wire logic                 sync_error_pin,
  input  wire logic [7:0]           rx_byte,
  input  wire logic                 rx_byte_valid,
  input  wire logic                 tx_byte_taken,
  output logic [7:0]                tx_byte,
  output logic                      tx_byte_valid,
  output logic                      uart_soft_reset,
  output logic                      uart_test_clock_sel,
  output logic                      any_irq_pending
);
  logic [7:0] midi_port_control;
  logic [7:0] midi_port_test;
  logic [7:0] rx_hold;
  logic       receive_byte_available;
  logic       sync_meta;
  logic       sync_sync;
  logic       sync_err_flag;
  logic       power_level_irq;
  logic       bus_master_irq;
  logic       uart_irq;
  logic       receive_irq_pending;
  logic       transmit_irq_pending;
  logic       transmit_ready;
  logic       receive_irq_enable;
  logic [1:0] transmit_irq_select;
  logic [1:0] port_command;
  logic       uart_run;
  logic       wr_data;
  logic       rd_data;
  logic       wr_ctl;
  logic       wr_test;
  logic [31:0] status_word;
  logic [7:0]  midi_status;

  function automatic logic byte_hit(input isu_pkg::isu_req_t r, input logic [5:0] a);
    byte_hit = r.valid && (r.addr[5:2] == a[5:2]) && r.byte_en[a[1:0]];
  endfunction : byte_hit

  assign receive_irq_enable  = midi_port_control[isu_pkg::BIT_RX_IRQ_EN];
  assign transmit_irq_select = midi_port_control[isu_pkg::TX_SEL_HI:isu_pkg::TX_SEL_LO];
  assign port_command        = midi_port_control[isu_pkg::CMD_HI:isu_pkg::CMD_LO];
  assign uart_run            = uart_enable && !uart_soft_reset;
  assign wr_data = byte_hit(req, isu_pkg::ADDR_MIDI_DATA) && req.write && uart_run;
  assign rd_data = byte_hit(req, isu_pkg::ADDR_MIDI_DATA) && !req.write;
  assign wr_ctl  = byte_hit(req, isu_pkg::ADDR_MIDI_STCTL) && req.write;
  assign wr_test = byte_hit(req, isu_pkg::ADDR_MIDI_TEST) && req.write;

  // Codec sync input synchroniser
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_meta <= 1'b0;
      sync_sync <= 1'b0;
    end else begin
      sync_meta <= sync_error_pin;
      sync_sync <= sync_meta;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sync_err_flag <= 1'b0;
    end else begin
      sync_err_flag <= sync_sync || src.sync_error;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      midi_port_control <= isu_pkg::MIDI_CTL_RESET;
    end else if (wr_ctl) begin
      midi_port_control <= req.wdata[15:8];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      uart_soft_reset <= 1'b0;
    end else begin
      uart_soft_reset <= wr_ctl && (req.wdata[9:8] == isu_pkg::CMD_SOFT_RESET);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      midi_port_test <= isu_pkg::MIDI_TEST_RESET;
    end else if (wr_test) begin
      midi_port_test <= {7'h00, req.wdata[16]};
    end
  end
  assign uart_test_clock_sel = midi_port_test[0];

  // receive holding byte, set wins over read
  always_ff @(posedge clk) begin
    if (sys_rst || uart_soft_reset) begin
      rx_hold                <= 8'h00;
      receive_byte_available <= 1'b0;
    end else if (rx_byte_valid && uart_run) begin
      rx_hold                <= rx_byte;
      receive_byte_available <= 1'b1;
    end else if (rd_data) begin
      receive_byte_available <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || uart_soft_reset) begin
      tx_byte       <= 8'h00;
      tx_byte_valid <= 1'b0;
    end else if (wr_data) begin
      tx_byte       <= req.wdata[7:0];
      tx_byte_valid <= 1'b1;
    end else if (tx_byte_taken) begin
      tx_byte_valid <= 1'b0;
    end
  end

  assign transmit_ready       = uart_run && !tx_byte_valid;
  assign receive_irq_pending  = receive_byte_available && receive_irq_enable;
  assign transmit_irq_pending = transmit_ready && (transmit_irq_select == isu_pkg::TX_SEL_READY);
  assign uart_irq             = receive_irq_pending || transmit_irq_pending;
  assign power_level_irq      = power_change_irq_mask &&
                                (config_power_state != current_power_level);
  assign bus_master_irq       = src.bus_master_irq_raw && bus_master_irq_mask;

  always_comb begin
    midi_status = 8'h00;
    midi_status[isu_pkg::BIT_RX_IRQ]   = receive_irq_pending;
    midi_status[isu_pkg::BIT_TX_IRQ]   = transmit_irq_pending;
    midi_status[isu_pkg::BIT_TX_READY] = transmit_ready;
    midi_status[isu_pkg::BIT_RX_AVAIL] = receive_byte_available;
  end

  always_comb begin
    status_word = {any_irq_pending, isu_pkg::STATUS_ONES, sync_err_flag,
                   src.voice_source_code, power_level_irq, bus_master_irq,
                   uart_irq, src.first_playback_irq, src.second_playback_irq,
                   src.record_irq};
  end

  assign any_irq_pending = src.first_playback_irq || src.second_playback_irq ||
                           src.record_irq || uart_irq || bus_master_irq ||
                           power_level_irq;

  // full-word read of status; byte reads of UART lanes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata  <= 32'h00000000;
      rvalid <= 1'b0;
    end else begin
      rvalid <= req.valid && !req.write;
      rdata  <= 32'h00000000;
      if (req.valid && !req.write) begin
        if (req.addr[5:2] == isu_pkg::ADDR_IRQ_STATUS[5:2] && req.byte_en == 4'hf) begin
          rdata <= status_word;
        end else if (req.addr[5:2] == isu_pkg::ADDR_MIDI_DATA[5:2]) begin
          rdata <= {8'h00, midi_port_test, midi_status, rx_hold};
        end
      end
    end
  end
endmodule : isu_irq_status_and_midi_uart

// *** logic/isu_pkg.sv ***
package isu_pkg;
  localparam logic [5:0]  ADDR_IRQ_STATUS  = 6'h04;
  localparam logic [5:0]  ADDR_MIDI_DATA   = 6'h08;
  localparam logic [5:0]  ADDR_MIDI_STCTL  = 6'h09;
  localparam logic [5:0]  ADDR_MIDI_TEST   = 6'h0a;
  localparam logic [31:0] IRQ_STATUS_RESET = 32'h7ffffec0;
  localparam logic [21:0] STATUS_ONES      = 22'h3fffff;
  localparam int          BIT_ANY_IRQ      = 31;
  localparam int          BIT_SYNC_ERR     = 8;
  localparam int          BIT_RX_IRQ       = 7;
  localparam int          BIT_TX_IRQ       = 2;
  localparam int          BIT_TX_READY     = 1;
  localparam int          BIT_RX_AVAIL     = 0;
  localparam int          BIT_RX_IRQ_EN    = 7;
  localparam int          TX_SEL_HI        = 6;
  localparam int          TX_SEL_LO        = 5;
  localparam int          CMD_HI           = 1;
  localparam int          CMD_LO           = 0;
  localparam logic [1:0]  TX_SEL_READY     = 2'h1;
  localparam logic [1:0]  CMD_SOFT_RESET   = 2'h3;
  localparam logic [7:0]  MIDI_CTL_RESET   = 8'h00;
  localparam logic [7:0]  MIDI_TEST_RESET  = 8'h00;

  typedef struct packed {
    logic first_playback_irq;
    logic second_playback_irq;
    logic record_irq;
    logic bus_master_irq_raw;
    logic [1:0] voice_source_code;
    logic sync_error;
  } isu_sources_t;

  typedef struct packed {
    logic       valid;
    logic       write;
    logic [5:0] addr;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } isu_req_t;
endpackage : isu_pkg

// *** test/isu_properties.sv ***
`timescale 1ns/1ps
module isu_properties (
  input wire logic                  clk,
  input wire logic                  sys_rst,
  input wire isu_pkg::isu_req_t     req,
  input wire logic [31:0]           rdata,
  input wire isu_pkg::isu_sources_t src,
  input wire logic                  bus_master_irq_mask,
  input wire logic                  uart_enable,
  input wire logic [7:0]            tx_byte,
  input wire logic                  tx_byte_valid,
  input wire logic                  uart_soft_reset,
  input wire logic                  uart_test_clock_sel,
  input wire logic                  any_irq_pending
);
  logic st_rd;
  logic wr_on;
  assign st_rd = req.valid && !req.write && req.addr == 6'h04;
  assign wr_on = req.valid && req.write;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_any; (src[6:4] != 3'h0 || (src.bus_master_irq_raw && bus_master_irq_mask))
    |-> any_irq_pending; endproperty
  a_any: assert property (p_any) else $error("summary flag low");
  property p_ones; st_rd && req.byte_en == 4'hf |=> rdata[30:9] == isu_pkg::STATUS_ONES;
    endproperty
  a_ones: assert property (p_ones) else $error("ones field wrong");
  property p_vc; st_rd && req.byte_en == 4'hf |=> rdata[7:6] == $past(src.voice_source_code);
    endproperty
  a_vc: assert property (p_vc) else $error("voice code wrong");
  property p_ccb; st_rd && req.byte_en == 4'hf
    |=> rdata[4] == $past(src.bus_master_irq_raw && bus_master_irq_mask); endproperty
  a_ccb: assert property (p_ccb) else $error("bus master flag wrong");
  property p_chan; st_rd && req.byte_en == 4'hf |=> rdata[2:0] == $past(src[6:4]); endproperty
  a_chan: assert property (p_chan) else $error("channel flags wrong");
  property p_part; st_rd && req.byte_en != 4'hf |=> rdata == 32'h0; endproperty
  a_part: assert property (p_part) else $error("partial status read");
  property p_tx; wr_on && req.addr == 6'h08 && req.byte_en[0] && uart_enable
    |=> tx_byte_valid && tx_byte == $past(req.wdata[7:0]); endproperty
  a_tx: assert property (p_tx) else $error("tx byte not queued");
  property p_srst; wr_on && req.addr == 6'h09 && req.byte_en[1] && req.wdata[9:8] == 2'h3
    |=> uart_soft_reset; endproperty
  a_srst: assert property (p_srst) else $error("no soft reset");
  property p_test; wr_on && req.addr == 6'h0a && req.byte_en[2]
    |=> uart_test_clock_sel == $past(req.wdata[16]); endproperty
  a_test: assert property (p_test) else $error("test clock select wrong");
endmodule : isu_properties

// *** test/tb_irq_status_and_midi_uart.sv ***
`timescale 1ns/1ps
module tb_irq_status_and_midi_uart;
  localparam logic [31:0] IDLE = isu_pkg::IRQ_STATUS_RESET;
  logic clk, sys_rst, rvalid, bmm, pmm, uen, sync_pin, rxv, txk, txv, srst, tsel, anyi;
  logic [1:0]            cpl, cps;
  logic [7:0]            rxb, txb;
  logic [31:0]           rdata, q;
  isu_pkg::isu_req_t     req;
  isu_pkg::isu_sources_t src;
  int                    fail_count, n_tests, i;
  isu_irq_status_and_midi_uart isu_irq_status_and_midi_uart_inst (.clk(clk), .sys_rst(sys_rst),
    .req(req), .rdata(rdata), .rvalid(rvalid), .src(src), .bus_master_irq_mask(bmm),
    .power_change_irq_mask(pmm), .current_power_level(cpl), .config_power_state(cps),
    .uart_enable(uen), .sync_error_pin(sync_pin), .rx_byte(rxb), .rx_byte_valid(rxv),
    .tx_byte_taken(txk), .tx_byte(txb), .tx_byte_valid(txv), .uart_soft_reset(srst),
    .uart_test_clock_sel(tsel), .any_irq_pending(anyi));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
    n_tests++;
    if ((got & m) !== (exp & m)) begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got & m, exp & m);
    end
  endtask : chk
  task automatic acc(input logic w, input logic [5:0] a, input logic [3:0] be,
                     input logic [31:0] d);
    @(negedge clk);
    req = '{1'b1, w, a, be, d};
    @(negedge clk);
    req.valid = 1'b0;
    if (!w && rvalid !== 1'b1) begin
      fail_count++;
      $display("Error %0t: no read answer", $time);
      give_verdict();
    end
    q = rdata;
  endtask : acc
  task automatic stat(input logic [31:0] e);
    acc(1'b0, 6'h04, 4'hf, 32'h0);
    chk(q, e, 32'hffffffff);
  endtask : stat
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    {sys_rst, bmm, pmm, uen, sync_pin, rxv, txk, cpl, cps, rxb} = {1'b1, 18'h0};
    req = '0;
    src = 7'h06;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    stat(IDLE);
    acc(1'b0, 6'h04, 4'h1, 32'h0); chk(q, 32'h0, 32'hffffffff);
    acc(1'b1, 6'h04, 4'hf, 32'h0); stat(IDLE);
    acc(1'b0, 6'h0a, 4'h4, 32'h0); chk(q, 32'h0, 32'h00010000);
    acc(1'b0, 6'h09, 4'h2, 32'h0); chk(q, 32'h0, 32'h0000f800);
    $display("reset test done");
    for (i = 0; i < 3; i++) begin
      src[6-i] = 1'b1;
      stat(IDLE | 32'h80000000 | (32'h4 >> i));
      src[6-i] = 1'b0;
    end
    src = 7'h0c;
    stat(32'h7ffffe80);
    bmm = 1'b1; stat(32'hfffffe90);
    src = 7'h06; cps = 2'h3; stat(IDLE);
    pmm = 1'b1; stat(IDLE | 32'h80000020);
    cpl = 2'h3; stat(IDLE);
    sync_pin = 1'b1; src.sync_error = 1'b1; repeat (3) @(negedge clk);
    stat(IDLE | 32'h100);
    $display("status test done");
    acc(1'b1, 6'h08, 4'h1, 32'h3c); chk({31'h0, txv}, 32'h0, 32'h1);
    uen = 1'b1; acc(1'b1, 6'h09, 4'h2, 32'h8000);
    rxb = 8'h5a; rxv = 1'b1; @(negedge clk); rxv = 1'b0;
    acc(1'b0, 6'h09, 4'h2, 32'h0); chk(q, 32'h8300, 32'hff00);
    stat(IDLE | 32'h80000108);
    acc(1'b0, 6'h08, 4'h1, 32'h0); chk(q, 32'h5a, 32'hff);
    acc(1'b0, 6'h09, 4'h2, 32'h0); chk(q, 32'h0200, 32'hff00);
    acc(1'b1, 6'h08, 4'h1, 32'h3c); chk({txv, txb}, 32'h13c, 32'h1ff);
    acc(1'b0, 6'h09, 4'h2, 32'h0); chk(q, 32'h0, 32'h0200);
    txk = 1'b1; @(negedge clk); txk = 1'b0;
    acc(1'b1, 6'h09, 4'h2, 32'h2000); acc(1'b0, 6'h09, 4'h2, 32'h0);
    chk(q, 32'h0600, 32'hff00);
    acc(1'b1, 6'h09, 4'h2, 32'h0300); chk({31'h0, srst}, 32'h1, 32'h1);
    acc(1'b1, 6'h0a, 4'h4, 32'h10000); chk({31'h0, tsel}, 32'h1, 32'h1);
    acc(1'b0, 6'h0a, 4'h4, 32'h0); chk(q, 32'h10000, 32'h10000);
    $display("uart test done");
    give_verdict();
  end
endmodule : tb_irq_status_and_midi_uart
bind isu_irq_status_and_midi_uart isu_properties isu_properties_inst (.clk(clk),
  .sys_rst(sys_rst), .req(req), .rdata(rdata), .src(src), .uart_enable(uart_enable),
  .bus_master_irq_mask(bus_master_irq_mask), .tx_byte(tx_byte), .tx_byte_valid(tx_byte_valid),
  .uart_soft_reset(uart_soft_reset), .uart_test_clock_sel(uart_test_clock_sel),
  .any_irq_pending(any_irq_pending));
